/* src/dpau_pkg.sv */
// Package for the dual pointer address unit: map, fields, opcodes, timing
package dpau_pkg;

  // ****************************************************************
  // Register word indices (byte address is four times the index)
  // ****************************************************************
  localparam logic [7:0]  IDX_LIMIT   = 8'hE3;  // Circular buffer limit
  localparam logic [7:0]  IDX_MODE    = 8'hE2;  // Signal proc mode reg
  localparam logic [7:0]  IDX_CONFIG  = 8'hA2;  // Pointer configuration
  localparam logic [7:0]  IDX_PTRZERO = 8'hF0;  // Pointer zero value
  localparam logic [7:0]  IDX_PTRONE  = 8'hF1;  // Pointer one value

  // ****************************************************************
  // Field positions
  // ****************************************************************
  localparam int MODE_REDIRECT = 0;  // Redirect to B bit
  localparam int MODE_IDXDIS   = 1;  // Index disable bit
  localparam int MODE_CIRC0    = 2;  // Circular enable, pointer zero
  localparam int MODE_CIRC1    = 3;  // Circular enable, pointer one
  localparam int CFG_SELECT    = 0;  // Pointer select bit
  localparam int CFG_DIR0      = 4;  // Direction bit, pointer zero
  localparam int CFG_DIR1      = 5;  // Direction bit, pointer one
  localparam int CFG_UPD0      = 6;  // Auto-update bit, pointer zero
  localparam int CFG_UPD1      = 7;  // Auto-update bit, pointer one

  // ****************************************************************
  // Reset values and buffer bases
  // ****************************************************************
  localparam logic [7:0]  LIMIT_RESET = 8'h00;
  localparam logic [7:0]  MODE_RESET  = 8'h00;
  localparam logic [7:0]  CFG_RESET   = 8'h00;
  localparam logic [15:0] PTR_RESET   = 16'h0000;
  localparam logic [7:0]  BUF_A_PAGE  = 8'h00;  // Buffer A from 0000H
  localparam logic [7:0]  BUF_B_PAGE  = 8'h01;  // Buffer B from 0100H

  // ****************************************************************
  // Opcodes (second byte when the prefix is present)
  // ****************************************************************
  localparam logic [7:0] OP_PREFIX  = 8'hA5;
  localparam logic [7:0] OP_LOADIMM = 8'h90;
  localparam logic [7:0] OP_MOVC    = 8'h93;
  localparam logic [7:0] OP_INC     = 8'hA3;
  localparam logic [7:0] OP_XREAD   = 8'hE0;
  localparam logic [7:0] OP_XWRITE  = 8'hF0;

  // ****************************************************************
  // Instruction cycle counts
  // ****************************************************************
  localparam logic [2:0] CYC_LOADIMM = 3'h4;
  localparam logic [2:0] CYC_MOVC    = 3'h4;
  localparam logic [2:0] CYC_INC     = 3'h3;
  localparam logic [2:0] CYC_XFAST   = 3'h3;
  localparam logic [2:0] CYC_XSLOW   = 3'h5;

  // Engine states, one-hot
  typedef enum logic [1:0] {
    ST_IDLE = 2'b01,
    ST_RUN  = 2'b10
  } dpau_state_t;

endpackage

/* src/dpau_dual_pointer_address_unit.sv */
// Dual data pointer address unit with circular buffers and AHB-Lite registers
`timescale 1ns/1ps
`default_nettype none

module dpau_dual_pointer_address_unit
  import dpau_pkg::*;
(
  input  wire logic        clk_sys,       // System clock, 125 MHz
  input  wire logic        nrst,          // Asynchronous reset, active low
  // AHB-Lite slave
  input  wire logic        hsel,          // Slave select
  input  wire logic [31:0] haddr,         // Byte address
  input  wire logic [1:0]  htrans,        // Transfer type
  input  wire logic        hwrite,        // Write when high
  input  wire logic [2:0]  hsize,         // Transfer size
  input  wire logic [31:0] hwdata,        // Write data
  input  wire logic        hready,        // Bus ready
  output logic      [31:0] hrdata,        // Read data
  output logic             hreadyout,     // Slave ready
  output logic             hresp,         // Response, always OKAY
  // Instruction side from the decoder
  input  wire logic        opStart,       // Start pulse for one instruction
  input  wire logic        opPrefix,      // A5 prefix seen before opCode
  input  wire logic [7:0]  opCode,        // Opcode byte
  input  wire logic [15:0] opImm,         // Immediate for pointer load
  input  wire logic [7:0]  accIn,         // Accumulator value
  input  wire logic [7:0]  bIn,           // B register value
  input  wire logic        xdataSlow,     // Data access takes long timing
  input  wire logic [7:0]  memRdata,      // Read data from memory path
  // Memory path and results
  output logic             opBusy,        // Instruction in progress
  output logic             opDone,        // Pulse on last cycle
  output logic             memReq,        // Access in progress
  output logic             memCode,       // Code space when high
  output logic             memWrite,      // Data write when high
  output logic      [15:0] memAddr,       // Access address
  output logic      [7:0]  memWdata,      // Write data
  output logic             resValid,      // Read result pulse
  output logic             resToB,        // Result goes to B, not A
  output logic      [7:0]  resData        // Read result
);

  // ****************************************************************
  // Helper functions
  // ****************************************************************
  // Next pointer value; wrap test uses the value before the step
  function automatic logic [15:0] stepPtr(
    input logic [15:0] ptr,
    input logic        dec,
    input logic        circ,
    input logic [7:0]  lim
  );
    logic [15:0] res;
    res = dec ? ptr - 16'h0001 : ptr + 16'h0001;
    if (circ)  // Region from the address only
    begin
      if (!dec && ptr == {BUF_A_PAGE, lim})
        res = {BUF_A_PAGE, 8'h00};
      else if (!dec && ptr == {BUF_B_PAGE, lim})
        res = {BUF_B_PAGE, 8'h00};
      else if (dec && ptr == {BUF_A_PAGE, 8'h00})
        res = {BUF_A_PAGE, lim};
      else if (dec && ptr == {BUF_B_PAGE, 8'h00})
        res = {BUF_B_PAGE, lim};
    end
    return res;
  endfunction
  // Register index hit on a word-aligned byte address
  function automatic logic hitIdx(
    input logic [31:0] addr,
    input logic [7:0]  idx
  );
    return addr == {22'h0, idx, 2'b00};
  endfunction

  // ****************************************************************
  // Register state
  // ****************************************************************
  logic [7:0]  limit_q, limit_d;      // Circular buffer limit
  logic [7:0]  mode_q, mode_d;        // Signal proc mode reg
  logic [7:0]  cfg_q, cfg_d;          // Pointer configuration
  logic [15:0] ptrZero_q, ptrZero_d;  // Pointer zero
  logic [15:0] ptrOne_q, ptrOne_d;    // Pointer one
  logic        wrPend_q, wrPend_d;    // Write data phase pending
  logic [31:0] wrAddr_q, wrAddr_d;    // Captured write address
  logic [31:0] hrdata_d;              // Next read data
  // Engine state
  dpau_state_t state_q, state_d;      // Engine state
  logic [2:0]  cnt_q, cnt_d;          // Cycles left in instruction
  logic        rdPend_q, rdPend_d;    // Result to capture at the end
  logic        busy_d, done_d, req_d, code_d, wr_d;
  logic [15:0] addr_d;
  logic [7:0]  wdata_d, resData_d;
  logic        resValid_d, resToB_d, toB_q, toB_d;
  // Pointer update request from the engine
  logic        updZero, updOne;       // Pointer gets updValue
  logic [15:0] updValue;
  // ****************************************************************
  // Instruction engine, next state
  // ****************************************************************
  // Address is computed from the current pointer; the post-update is
  // written at the same edge, so a back-to-back instruction sees it.
  always_comb
  begin
    logic        useOne;     // Pointer one is the one addressed
    logic [15:0] ptr;
    logic        dirBit, updBit, circBit, redir;
    // Prefix addresses the alternate pointer
    useOne  = cfg_q[CFG_SELECT] ^ opPrefix;
    ptr     = useOne ? ptrOne_q : ptrZero_q;
    dirBit  = useOne ? cfg_q[CFG_DIR1] : cfg_q[CFG_DIR0];
    updBit  = useOne ? cfg_q[CFG_UPD1] : cfg_q[CFG_UPD0];
    circBit = useOne ? mode_q[MODE_CIRC1] : mode_q[MODE_CIRC0];
    redir   = useOne & mode_q[MODE_REDIRECT];
    state_d  = state_q;
    cnt_d    = cnt_q;
    rdPend_d = rdPend_q;
    busy_d   = opBusy;
    done_d   = 1'b0;
    req_d    = memReq;
    code_d   = memCode;
    wr_d     = memWrite;
    addr_d   = memAddr;
    wdata_d  = memWdata;
    toB_d    = toB_q;
    resValid_d = 1'b0;
    resToB_d   = resToB;
    resData_d  = resData;
    updZero  = 1'b0;
    updOne   = 1'b0;
    updValue = 16'h0000;
    case (state_q)
      ST_IDLE:
      begin
        if (opStart)
        begin
          // Default: unknown opcode finishes at once, no access
          state_d  = ST_RUN;
          busy_d   = 1'b1;
          cnt_d    = 3'h1;
          rdPend_d = 1'b0;
          req_d    = 1'b0;
          code_d   = 1'b0;
          wr_d     = 1'b0;
          toB_d    = 1'b0;
          case (opCode)
            OP_LOADIMM:
            begin
              cnt_d    = CYC_LOADIMM;
              updValue = opImm;
              updZero  = ~useOne;
              updOne   = useOne;
            end
            OP_INC:
            begin
              cnt_d    = CYC_INC;
              updValue = stepPtr(ptr, dirBit, circBit, limit_q);
              updZero  = ~useOne;
              updOne   = useOne;
            end
            OP_MOVC:
            begin
              cnt_d    = CYC_MOVC;
              req_d    = 1'b1;
              code_d   = 1'b1;
              rdPend_d = 1'b1;
              toB_d    = redir;
              // Accumulator stays the index even when redirected
              addr_d   = mode_q[MODE_IDXDIS] ? ptr
                         : ptr + {8'h00, accIn};
              updValue = stepPtr(ptr, dirBit, circBit, limit_q);
              updZero  = updBit & ~useOne;
              updOne   = updBit & useOne;
            end
            OP_XREAD, OP_XWRITE:
            begin
              cnt_d    = xdataSlow ? CYC_XSLOW : CYC_XFAST;
              req_d    = 1'b1;
              wr_d     = (opCode == OP_XWRITE);
              rdPend_d = (opCode == OP_XREAD);
              toB_d    = redir;
              wdata_d  = redir ? bIn : accIn;
              addr_d   = ptr;
              updValue = stepPtr(ptr, dirBit, circBit, limit_q);
              updZero  = updBit & ~useOne;
              updOne   = updBit & useOne;
            end
            default: cnt_d = 3'h1;  // Unknown opcode: one cycle, no access
          endcase
          // Single-cycle instruction finishes at the next edge
          done_d = (cnt_d == 3'h1);
        end
      end
      ST_RUN:
      begin
        if (cnt_q == 3'h1 || done_d)
        begin
          state_d  = ST_IDLE;
          busy_d   = 1'b0;
          req_d    = 1'b0;
          wr_d     = 1'b0;
          cnt_d    = 3'h0;
          rdPend_d = 1'b0;
          resValid_d = rdPend_q;
          resToB_d   = toB_q;
          resData_d  = rdPend_q ? memRdata : resData;
        end
        else
        begin
          cnt_d  = cnt_q - 3'h1;
          done_d = (cnt_q == 3'h2);
        end
      end
      default:
      begin
        state_d = ST_IDLE;
        busy_d  = 1'b0;
        req_d   = 1'b0;
        wr_d    = 1'b0;
        cnt_d   = 3'h0;
      end
    endcase
  end

  // ****************************************************************
  // Instruction engine, registers
  // ****************************************************************
  always_ff @(posedge clk_sys or negedge nrst)
  begin
    if (!nrst)
    begin
      state_q  <= ST_IDLE;
      cnt_q    <= 3'h0;
      rdPend_q <= 1'b0;
      toB_q    <= 1'b0;
      opBusy   <= 1'b0;
      opDone   <= 1'b0;
      memReq   <= 1'b0;
      memCode  <= 1'b0;
      memWrite <= 1'b0;
      memAddr  <= 16'h0000;
      memWdata <= 8'h00;
      resValid <= 1'b0;
      resToB   <= 1'b0;
      resData  <= 8'h00;
    end
    else
    begin
      state_q  <= state_d;
      cnt_q    <= cnt_d;
      rdPend_q <= rdPend_d;
      toB_q    <= toB_d;
      opBusy   <= busy_d;
      opDone   <= done_d;
      memReq   <= req_d;
      memCode  <= code_d;
      memWrite <= wr_d;
      memAddr  <= addr_d;
      memWdata <= wdata_d;
      resValid <= resValid_d;
      resToB   <= resToB_d;
      resData  <= resData_d;
    end
  end
  // ****************************************************************
  // AHB-Lite slave and register file, next state
  // ****************************************************************
  // Zero wait states; a bus write to a pointer wins over an update by
  // the engine in the same cycle, as software is taken to know best.
  always_comb
  begin
    logic addrPhase;
    addrPhase = hsel & hready & htrans[1];
    limit_d   = limit_q;
    mode_d    = mode_q;
    cfg_d     = cfg_q;
    ptrZero_d = updZero ? updValue : ptrZero_q;
    ptrOne_d  = updOne ? updValue : ptrOne_q;
    wrPend_d  = addrPhase & hwrite;
    wrAddr_d  = addrPhase ? haddr : wrAddr_q;
    hrdata_d  = hrdata;
    // Data phase of a write
    if (wrPend_q)
    begin
      if (hitIdx(wrAddr_q, IDX_LIMIT))
        limit_d = hwdata[7:0];
      if (hitIdx(wrAddr_q, IDX_MODE))
        mode_d = {4'h0, hwdata[3:0]};
      if (hitIdx(wrAddr_q, IDX_CONFIG))
        cfg_d = {hwdata[7:4], 3'h0, hwdata[0]};
      if (hitIdx(wrAddr_q, IDX_PTRZERO))
        ptrZero_d = hwdata[15:0];
      if (hitIdx(wrAddr_q, IDX_PTRONE))
        ptrOne_d = hwdata[15:0];
    end
    // Read data prepared in the address phase; unmapped reads zero
    if (addrPhase && !hwrite)
    begin
      hrdata_d = 32'h0000_0000;
      if (hitIdx(haddr, IDX_LIMIT))
        hrdata_d = {24'h0, limit_q};
      if (hitIdx(haddr, IDX_MODE))
        hrdata_d = {24'h0, mode_q};
      if (hitIdx(haddr, IDX_CONFIG))
        hrdata_d = {24'h0, cfg_q};
      if (hitIdx(haddr, IDX_PTRZERO))
        hrdata_d = {16'h0, ptrZero_q};
      if (hitIdx(haddr, IDX_PTRONE))
        hrdata_d = {16'h0, ptrOne_q};
    end
  end

  // ****************************************************************
  // AHB-Lite slave and register file, registers
  // ****************************************************************
  always_ff @(posedge clk_sys or negedge nrst)
  begin
    if (!nrst)
    begin
      limit_q   <= LIMIT_RESET;
      mode_q    <= MODE_RESET;
      cfg_q     <= CFG_RESET;
      ptrZero_q <= PTR_RESET;
      ptrOne_q  <= PTR_RESET;
      wrPend_q  <= 1'b0;
      wrAddr_q  <= 32'h0000_0000;
      hrdata    <= 32'h0000_0000;
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
    end
    else
    begin
      limit_q   <= limit_d;
      mode_q    <= mode_d;
      cfg_q     <= cfg_d;
      ptrZero_q <= ptrZero_d;
      ptrOne_q  <= ptrOne_d;
      wrPend_q  <= wrPend_d;
      wrAddr_q  <= wrAddr_d;
      hrdata    <= hrdata_d;
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
    end
  end

endmodule

`default_nettype wire

/* testbench/dpau_mem_model.sv */
// Memory path model that answers the address unit's accesses
`timescale 1ns/1ps
`default_nettype none

module dpau_mem_model (
  input  wire logic        clk_sys,
  input  wire logic        nrst,
  input  wire logic        memReq,
  input  wire logic        memCode,
  input  wire logic [15:0] memAddr,
  output logic      [7:0]  memRdata
);
  logic [7:0] idle_q;  // Pattern shown while no access runs
  logic [7:0] idle_d;

  // ****************************************************************
  // Idle pattern
  // ****************************************************************
  // Changes every cycle between A6 and 5A, so a stale sample can match by luck only an expected A6 or 5A
  always_comb
  begin
    idle_d = ~idle_q + 8'h01;
  end

  always_ff @(posedge clk_sys or negedge nrst)
  begin
    if (!nrst)
      idle_q <= 8'hA6;
    else
      idle_q <= idle_d;
  end

  // Code and data spaces hold different, address-derived bytes
  assign memRdata = !memReq ? idle_q :
                    memAddr[7:0] ^ (memCode ? 8'h5A : 8'hC3);
endmodule

`default_nettype wire

/* testbench/dpau_assertions.sv */
// Port checker for the dual pointer address unit
`timescale 1ns/1ps
`default_nettype none

module dpau_checker
  import dpau_pkg::*;
(
  input wire logic        clk_sys,
  input wire logic        nrst,
  input wire logic        hreadyout,
  input wire logic        hresp,
  input wire logic        opStart,
  input wire logic [7:0]  opCode,
  input wire logic        xdataSlow,
  input wire logic        opBusy,
  input wire logic        opDone,
  input wire logic        memReq,
  input wire logic        memCode,
  input wire logic        memWrite,
  input wire logic [15:0] memAddr,
  input wire logic        resValid
);
  // All checks sleep while reset is low
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!nrst);

  logic take;  // Instruction accepted at this edge
  assign take = opStart && !opBusy;

  a_bus_okay: assert property (hresp == 1'b0 && hreadyout == 1'b1)
    else $error("bus slave not ready or not okay");
  a_busy_follows: assert property (take |=> opBusy)
    else $error("busy did not follow start");
  a_load_len: assert property (
    take && opCode == OP_LOADIMM |=> opBusy [*4] ##1 !opBusy)
    else $error("pointer load length wrong");
  a_movc_len: assert property (
    take && opCode == OP_MOVC |=> (memReq && memCode) [*4] ##1 resValid)
    else $error("code read length wrong");
  a_read_fast: assert property (
    take && opCode == OP_XREAD && !xdataSlow
    |=> (memReq && !memCode && !memWrite) [*3] ##1 resValid)
    else $error("fast data read length wrong");
  a_read_slow: assert property (
    take && opCode == OP_XREAD && xdataSlow
    |=> (memReq && !memWrite) [*5] ##1 resValid)
    else $error("slow data read length wrong");
  a_write_fast: assert property (
    take && opCode == OP_XWRITE && !xdataSlow
    |=> (memReq && memWrite) [*3] ##1 (!opBusy && !resValid))
    else $error("fast data write length wrong");
  a_write_slow: assert property (
    take && opCode == OP_XWRITE && xdataSlow
    |=> (memReq && memWrite) [*5] ##1 !opBusy)
    else $error("slow data write length wrong");
  a_addr_stands: assert property (memReq && !opDone |=> $stable(memAddr))
    else $error("access address moved mid access");
  a_done_last: assert property (opDone |=> !opBusy ##0 !opDone)
    else $error("busy outlived done");

  c_load: cover property (take && opCode == OP_LOADIMM);
  c_slow: cover property (take && opCode == OP_XWRITE && xdataSlow);
  c_movc: cover property (take && opCode == OP_MOVC);
endmodule

bind dpau_dual_pointer_address_unit dpau_checker u_chk (
  .clk_sys(clk_sys), .nrst(nrst), .hreadyout(hreadyout),
  .hresp(hresp), .opStart(opStart), .opCode(opCode),
  .xdataSlow(xdataSlow), .opBusy(opBusy), .opDone(opDone),
  .memReq(memReq), .memCode(memCode), .memWrite(memWrite),
  .memAddr(memAddr), .resValid(resValid)
);

`default_nettype wire

/* testbench/dpau_dual_pointer_address_unit_tb.sv */
// Self-checking bench for the dual pointer address unit
`timescale 1ns/1ps
`default_nettype none

`define CHK(nm, exp, got) \
  begin \
    totalChecks++; \
    if ((got) !== (exp)) \
    begin \
      errTotal++; \
      $display("MISMATCH %s exp %0h got %0h", nm, exp, got); \
    end \
  end

module dpau_dual_pointer_address_unit_tb;
  import dpau_pkg::*;
  logic clk_sys, nrst, hsel, hwrite, hready, hreadyout, hresp;
  logic [31:0] haddr, hwdata, hrdata;
  logic [1:0]  htrans;
  logic [2:0]  hsize;
  logic opStart, opPrefix, xdataSlow, opBusy, opDone, memReq, memCode;
  logic memWrite, resValid, resToB;
  logic [7:0]  opCode, accIn, bIn, memRdata, memWdata, resData;
  logic [15:0] opImm, memAddr, sAddr;
  logic sWr, sCode, sRv, sToB;  // Samples taken during an instruction and right after it ends
  logic [7:0]  sWd, sRd;
  int errTotal, totalChecks, nBusy;

  assign hready = hreadyout;  // Single slave drives the bus ready

  dpau_dual_pointer_address_unit dut (.clk_sys, .nrst, .hsel, .haddr,
    .htrans, .hwrite, .hsize, .hwdata, .hready, .hrdata, .hreadyout,
    .hresp, .opStart, .opPrefix, .opCode, .opImm, .accIn, .bIn,
    .xdataSlow, .memRdata, .opBusy, .opDone, .memReq, .memCode,
    .memWrite, .memAddr, .memWdata, .resValid, .resToB, .resData);

  dpau_mem_model u_mem (.clk_sys, .nrst, .memReq, .memCode, .memAddr,
    .memRdata);

  initial
  begin
    clk_sys = 1'b0;
    forever #4 clk_sys = ~clk_sys;
  end

  // ****************************************************************
  // Bus and instruction drivers
  // ****************************************************************
  task automatic waitRdy;
    int n;
    n = 0;
    do
    begin
      @(posedge clk_sys);
      n++;
    end
    while (hready !== 1'b1 && n < 50);
    if (n >= 50)
    begin
      errTotal++;
      closeOut();
    end
  endtask

  // One single word transfer; read data taken at the data phase edge
  task automatic bus(input logic wr, input logic [7:0] idx,
                     input logic [31:0] wd, output logic [31:0] rd);
    @(posedge clk_sys);
    haddr <= {22'h000000, idx, 2'h0};
    hwrite <= wr;
    htrans <= 2'h2;
    waitRdy();
    htrans <= 2'h0;
    hwdata <= wd;
    waitRdy();
    rd = hrdata;
  endtask

  task automatic wr(input logic [7:0] idx, input logic [31:0] d);
    logic [31:0] x;
    bus(1'b1, idx, d, x);
  endtask

  task automatic rdChk(input logic [7:0] idx, input logic [31:0] exp,
                       input string nm);
    logic [31:0] x;
    bus(1'b0, idx, 32'h0, x);
    `CHK(nm, exp, x)
  endtask

  // Starts one instruction, samples the access, counts busy cycles
  task automatic op(input logic pre, input logic [7:0] code,
                    input logic slow, input logic [15:0] imm);
    @(posedge clk_sys);
    opStart <= 1'b1;
    opPrefix <= pre;
    opCode <= code;
    xdataSlow <= slow;
    opImm <= imm;
    @(posedge clk_sys);
    opStart <= 1'b0;
    #1;
    {sAddr, sWr, sWd, sCode} = {memAddr, memWrite, memWdata, memCode};
    nBusy = 0;
    while (opBusy === 1'b1 && nBusy < 20)
    begin
      nBusy++;
      @(posedge clk_sys);
      #1;
    end
    if (nBusy >= 20)
    begin
      errTotal++;
      closeOut();
    end
    {sRv, sToB, sRd} = {resValid, resToB, resData};
  endtask

  // ****************************************************************
  // Scenarios
  // ****************************************************************
  task automatic tRegs;
    rdChk(IDX_LIMIT, 32'h0, "limit reset");
    rdChk(8'h01, 32'h0, "unmapped");
    wr(IDX_LIMIT, 32'h1FF);
    rdChk(IDX_LIMIT, 32'hFF, "limit width");
    wr(IDX_LIMIT, 32'h0F);
    $display("test regs done");
  endtask

  // Fields: config, mode, prefix, start pointer, expected pointer
  task automatic tCirc;
    logic [51:0] t [8];
    logic tgt;
    t = '{{8'h00, 8'h04, 4'h0, 16'h000F, 16'h0000},
          {8'h10, 8'h04, 4'h0, 16'h0000, 16'h000F},
          {8'h00, 8'h04, 4'h0, 16'h010F, 16'h0100},
          {8'h21, 8'h08, 4'h0, 16'h0000, 16'h000F},
          {8'h00, 8'h08, 4'h0, 16'h000F, 16'h0010},
          {8'h00, 8'h0C, 4'h0, 16'h0010, 16'h0011},
          {8'h10, 8'h04, 4'h0, 16'h0110, 16'h010F},
          {8'h00, 8'h08, 4'h1, 16'hFFFF, 16'h0000}};
    foreach (t[i])
    begin
      wr(IDX_CONFIG, {24'h0, t[i][51:44]});
      wr(IDX_MODE, {24'h0, t[i][43:36]});
      wr(IDX_PTRZERO, {16'h0, t[i][31:16]});
      wr(IDX_PTRONE, {16'h0, t[i][31:16]});
      op(t[i][32], OP_INC, 1'b0, 16'h0);
      `CHK("inc cycles", 3, nBusy)
      tgt = t[i][44] ^ t[i][32];
      rdChk(tgt ? IDX_PTRONE : IDX_PTRZERO, {16'h0, t[i][15:0]},
            "stepped ptr");
      rdChk(tgt ? IDX_PTRZERO : IDX_PTRONE, {16'h0, t[i][31:16]},
            "untouched ptr");
    end
    $display("test circular done");
  endtask

  // Fields: mode, config, prefix, expected address, result to B
  task automatic tMovc;
    logic [39:0] t [6];
    t = '{{8'h00, 8'h00, 4'h0, 16'h1244, 4'h0},
          {8'h02, 8'h00, 4'h0, 16'h1234, 4'h0},
          {8'h01, 8'h00, 4'h0, 16'h1244, 4'h0},
          {8'h01, 8'h00, 4'h1, 16'h2010, 4'h1},
          {8'h03, 8'h01, 4'h0, 16'h2000, 4'h1},
          {8'h01, 8'h01, 4'h1, 16'h1244, 4'h0}};
    wr(IDX_PTRZERO, 32'h1234);
    wr(IDX_PTRONE, 32'h2000);
    foreach (t[i])
    begin
      wr(IDX_MODE, {24'h0, t[i][39:32]});
      wr(IDX_CONFIG, {24'h0, t[i][31:24]});
      op(t[i][20], OP_MOVC, 1'b0, 16'h0);
      `CHK("code addr", t[i][19:4], sAddr)
      `CHK("code space", 1'b1, sCode)
      `CHK("code cycles", 4, nBusy)
      `CHK("to b", t[i][0], sToB)
      `CHK("code data", t[i][11:4] ^ 8'h5A, sRd)
      `CHK("result valid", 1'b1, sRv)
    end
    // Code read with auto-update: address from the old value, then step
    wr(IDX_MODE, 32'h00);
    wr(IDX_CONFIG, 32'h40);
    op(1'b0, OP_MOVC, 1'b0, 16'h0);
    `CHK("upd code addr", 16'h1244, sAddr)
    rdChk(IDX_PTRZERO, 32'h1235, "code post inc");
    $display("test code read done");
  endtask

  // Fields: prefix, opcode, slow, address, write, value, cycles
  task automatic tXdata;
    logic [47:0] t [4];
    t = '{{4'h0, OP_XREAD, 4'h0, 16'h000F, 4'h0, 8'h00, 4'h3},
          {4'h1, OP_XWRITE, 4'h1, 16'h0300, 4'h1, 8'h77, 4'h5},
          {4'h1, OP_XREAD, 4'h0, 16'h0300, 4'h0, 8'h01, 4'h3},
          {4'h0, OP_XWRITE, 4'h1, 16'h0000, 4'h1, 8'h10, 4'h5}};
    wr(IDX_PTRZERO, 32'h000F);
    wr(IDX_PTRONE, 32'h0300);
    wr(IDX_MODE, 32'h05);
    wr(IDX_CONFIG, 32'h40);
    foreach (t[i])
    begin
      op(t[i][44], t[i][43:36], t[i][32], 16'h0);
      `CHK("data addr", t[i][31:16], sAddr)
      `CHK("data dir", t[i][12], sWr)
      `CHK("data cycles", int'(t[i][3:0]), nBusy)
      if (t[i][12])
        `CHK("write data", t[i][11:4], sWd)
      else
        `CHK("read to b", t[i][4], sToB)
    end
    rdChk(IDX_PTRZERO, 32'h0001, "auto ptr");
    rdChk(IDX_PTRONE, 32'h0300, "fixed ptr");
    $display("test data access done");
  endtask

  task automatic tLoad;
    wr(IDX_CONFIG, 32'h01);
    op(1'b1, OP_LOADIMM, 1'b0, 16'hBEEF);
    `CHK("load cycles", 4, nBusy)
    rdChk(IDX_PTRZERO, 32'hBEEF, "load alt");
    wr(IDX_CONFIG, 32'h00);
    op(1'b1, OP_LOADIMM, 1'b0, 16'h1357);
    rdChk(IDX_PTRONE, 32'h1357, "load alt one");
    op(1'b0, 8'h00, 1'b0, 16'h0);
    `CHK("no-op cycles", 1, nBusy)
    $display("test load done");
  endtask

  task automatic closeOut;
    $display("checks %0d mismatches %0d", totalChecks, errTotal);
    if (errTotal == 0 && totalChecks > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask

  initial
  begin
    {nrst, hsel, hwrite, htrans, haddr, hwdata} = '0;
    {opStart, opPrefix, opCode, opImm, xdataSlow} = '0;
    {hsel, hsize, accIn, bIn} = {1'b1, 3'h2, 8'h10, 8'h77};
    {errTotal, totalChecks} = '0;
    repeat (6) @(posedge clk_sys);
    nrst <= 1'b1;
    tRegs();
    tCirc();
    tMovc();
    tXdata();
    tLoad();
    closeOut();
  end
endmodule

`default_nettype wire
